// [hdl/b3rc_pkg.sv]
package b3rc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_ENABLE_CONTROL = 8'h01;
  localparam logic [7:0] OFS_WAIT = 8'h02;
  localparam logic [7:0] OFS_VCHG = 8'h03;
  localparam logic [7:0] OFS_RAMP = 8'h04;
  localparam logic [7:0] OFS_B1V1 = 8'h05;
  localparam logic [7:0] OFS_B3V1 = 8'h06;
  localparam logic [7:0] OFS_B3V2 = 8'h07;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_OUTPUT_ENABLE_CONTROL = 8'h00;
  localparam logic [7:0] RST_WAIT = 8'h00;
  localparam logic [7:0] RST_VCHG = 8'h00;
  localparam logic [7:0] RST_RAMP = 8'h3F;
  localparam logic [7:0] RST_B1V1 = 8'h19;
  localparam logic [7:0] RST_B3V1 = 8'h19;
  localparam logic [7:0] RST_B3V2 = 8'h19;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MODE_LSB = 4;
  localparam int OUTPUT_ENABLE_CONTROL_BIT = 2;
  localparam int WAIT_BIT = 2;
  localparam int SEL_BIT = 5;
  localparam int INIT_BIT = 4;
  localparam int RATE_LSB = 4;
  localparam int PGN_BIT = 5;
  localparam int FREQ_BIT = 5;
  localparam int PHASE_BIT = 6;
  localparam int KEEP_BIT = 7;
  localparam int EDGE_LSB = 6;

  localparam logic [1:0] MODE_SKIP = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_FCCM = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_KHZ = 125000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int FSW_FULL_KHZ = 2250;
  localparam int FSW_HALF_KHZ = 1125;
  localparam int DUTY_FULL_PCT = 20;
  localparam int DUTY_HALF_PCT = 50;
  localparam logic [6:0] PER_FULL = 7'(CLK_KHZ / FSW_FULL_KHZ);
  localparam logic [6:0] PER_HALF = 7'(CLK_KHZ / FSW_HALF_KHZ);
  localparam logic [6:0] HIGH_FULL = 7'(int'(PER_FULL) * DUTY_FULL_PCT / 100);
  localparam logic [6:0] HIGH_HALF = 7'(int'(PER_HALF) * DUTY_HALF_PCT / 100);
  localparam int MIN_ON_NS = 90;
  localparam logic [7:0] MIN_ON_CYC = 8'((MIN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int FRAC_BITS = 4;
  localparam int DAC_LSB_UV = 12500;
  localparam int SS_RATE_UVUS = 800;
  localparam int SLEW_RATE_UVUS [4] = '{880, 1750, 3500, 7000};
  localparam int STEP_NUM = DAC_LSB_UV * 1000 / ((1 << FRAC_BITS) * CLK_PERIOD_NS);
  localparam logic [15:0] SS_STEP_CYC = 16'(STEP_NUM / SS_RATE_UVUS);
  localparam logic [15:0] SLEW_STEP_CYC [4] = '{
    16'(STEP_NUM / SLEW_RATE_UVUS[0]), 16'(STEP_NUM / SLEW_RATE_UVUS[1]),
    16'(STEP_NUM / SLEW_RATE_UVUS[2]), 16'(STEP_NUM / SLEW_RATE_UVUS[3])};

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {ST_OFF, ST_WAIT, ST_SOFT, ST_RUN, ST_SLEW} b3rc_state_t;

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] output_enable_control;
    logic [7:0] wstart;
    logic [7:0] vchg;
    logic [7:0] ramp;
    logic [7:0] b1v1;
    logic [7:0] b3v1;
    logic [7:0] b3v2;
  } b3rc_regs_t;

  typedef struct packed {
    b3rc_regs_t regs;
    b3rc_state_t state;
    logic [8:0] ref_lvl;
    logic [15:0] step_cnt;
    logic [6:0] ph_cnt;
    logic [7:0] rd_data;
    logic rd_valid;
    logic run;
    logic [1:0] mode_out;
    logic sw_clk;
    logic cyc_start;
    logic cyc_skip;
    logic power_good_output;
    logic slewing;
  } b3rc_core_t;

endpackage

// [hdl/b3rc_top.sv]
// Overview of operation
// - The two-bit mode field picks pulse skipping (00, default), light-load sleep or forced continuous.
// - Each enable ramps the reference from zero to target at 0.8V/ms with pulse skipping forced.
// - The start-wait bit waits for output below 300mV when 0, polarity reversed on the second variant.
// - The select bit picks the first target register when 0 and the second when 1.
// - Writing 1 to the slew-initiate bit moves the reference toward the selected target.
// - The slew field sets 0.88, 1.75, 3.5 or 7 mV/us and resets to the fastest.
// - With the power-good policy bit at 0 power-good is held low while slewing.
// - The first target register holds a five-bit code resetting to 11001.
// - The second target register holds a five-bit code resetting to 11001.
// - Switching runs at 2.25MHz by default and at 1.125MHz when the frequency bit is set.
// - The phase bit delays each switching cycle by 20% at full rate and 50% at half rate.
// - The full-rate switching clock has 20% duty and the half-rate clock 50% duty.
// - The keep-alive bit keeps the regulator running through a system shutdown.
// - The switch-node edge rate comes from bits 7:6 of the first regulator's first target.
// - At power-on the edge-rate field selects the fastest transition.
// - When the needed on-time is below the 90ns minimum the cycle is skipped.
`timescale 1ns/1ps
`default_nettype none

module b3rc_top #(
  parameter bit VARIANT_SWAP = 1'b0
) (
  input wire logic CLK, // System clock
  input wire logic ARST_N, // Async reset
  input wire logic WR_EN, // Register write strobe
  input wire logic RD_EN, // Register read strobe
  input wire logic [7:0] ADDR, // Register offset
  input wire logic [7:0] WR_DATA, // Write data
  output logic [7:0] RD_DATA, // Read data
  output logic RD_VALID, // Read data valid
  input wire logic VOUT_LOW, // Output below 300mV
  input wire logic FAULT, // Fault, forces restart
  input wire logic SHUTDOWN, // System shutdown request
  input wire logic PG_SENSE, // Raw power-good comparator
  input wire logic [7:0] ON_TIME_CYC, // Required on-time, cycles
  output logic [8:0] REF_CODE, // Reference to DAC, 4 frac bits
  output logic RUN_OUT, // Regulator running
  output logic [1:0] MODE_OUT, // Active light-load mode
  output logic SW_CLK, // Switching clock
  output logic CYCLE_START, // Switching cycle begins
  output logic CYCLE_SKIP, // Switching cycle skipped
  output logic POWER_GOOD, // Power-good output
  output logic SLEWING, // Reference slewing
  output logic [1:0] EDGE_RATE // Switch-node edge rate
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  b3rc_pkg::b3rc_core_t q;
  b3rc_pkg::b3rc_core_t next_q;

  logic slew_req;
  logic en;
  logic wait_low;
  logic [8:0] tgt;
  logic [15:0] step_lim;
  logic half;
  logic [6:0] per;
  logic [6:0] hi;
  logic [6:0] dly;
  logic [6:0] pos;
  logic [1:0] mode_fld;
  logic new_sel;
  logic [8:0] sel_tgt;

  always_comb begin
    mode_fld = q.regs.mode[b3rc_pkg::MODE_LSB +: 2];
    slew_req = WR_EN && ADDR == b3rc_pkg::OFS_VCHG && WR_DATA[b3rc_pkg::INIT_BIT];
    en = q.regs.output_enable_control[b3rc_pkg::OUTPUT_ENABLE_CONTROL_BIT] && !FAULT &&
         !(SHUTDOWN && !q.regs.b3v2[b3rc_pkg::KEEP_BIT]);
    wait_low = !q.regs.wstart[b3rc_pkg::WAIT_BIT] ^ VARIANT_SWAP;
    tgt = q.regs.vchg[b3rc_pkg::SEL_BIT] ? {q.regs.b3v2[4:0], 4'h0}
                                         : {q.regs.b3v1[4:0], 4'h0};
    step_lim = (q.state == b3rc_pkg::ST_SOFT) ? b3rc_pkg::SS_STEP_CYC
             : b3rc_pkg::SLEW_STEP_CYC[q.regs.ramp[b3rc_pkg::RATE_LSB +: 2]];
    half = q.regs.b3v2[b3rc_pkg::FREQ_BIT];
    per = half ? b3rc_pkg::PER_HALF : b3rc_pkg::PER_FULL;
    hi = half ? b3rc_pkg::HIGH_HALF : b3rc_pkg::HIGH_FULL;
    dly = q.regs.b3v2[b3rc_pkg::PHASE_BIT] ? hi : 7'h00;
    pos = (q.ph_cnt >= dly) ? q.ph_cnt - dly : q.ph_cnt + per - dly;
    // Select written together with initiate applies at once
    new_sel = (WR_EN && ADDR == b3rc_pkg::OFS_VCHG) ? WR_DATA[b3rc_pkg::SEL_BIT]
                                                     : q.regs.vchg[b3rc_pkg::SEL_BIT];
    sel_tgt = new_sel ? {q.regs.b3v2[4:0], 4'h0} : {q.regs.b3v1[4:0], 4'h0};
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_q = q;
    next_q.rd_valid = 1'b0;
    next_q.cyc_start = 1'b0;
    next_q.cyc_skip = 1'b0;

    // Register writes; initiate bit never stored
    if (WR_EN) begin
      case (ADDR)
        b3rc_pkg::OFS_MODE: next_q.regs.mode = WR_DATA;
        b3rc_pkg::OFS_OUTPUT_ENABLE_CONTROL: next_q.regs.output_enable_control = WR_DATA;
        b3rc_pkg::OFS_WAIT: next_q.regs.wstart = WR_DATA;
        b3rc_pkg::OFS_VCHG: next_q.regs.vchg = WR_DATA & 8'hEF;
        b3rc_pkg::OFS_RAMP: next_q.regs.ramp = WR_DATA;
        b3rc_pkg::OFS_B1V1: next_q.regs.b1v1 = WR_DATA;
        b3rc_pkg::OFS_B3V1: next_q.regs.b3v1 = WR_DATA;
        b3rc_pkg::OFS_B3V2: next_q.regs.b3v2 = WR_DATA;
        default: ;
      endcase
    end

    // Register reads; initiate bit reads back slew in progress
    if (RD_EN) begin
      next_q.rd_valid = 1'b1;
      case (ADDR)
        b3rc_pkg::OFS_MODE: next_q.rd_data = q.regs.mode;
        b3rc_pkg::OFS_OUTPUT_ENABLE_CONTROL: next_q.rd_data = q.regs.output_enable_control;
        b3rc_pkg::OFS_WAIT: next_q.rd_data = q.regs.wstart;
        b3rc_pkg::OFS_VCHG: next_q.rd_data = q.regs.vchg | {3'h0, q.slewing, 4'h0};
        b3rc_pkg::OFS_RAMP: next_q.rd_data = q.regs.ramp;
        b3rc_pkg::OFS_B1V1: next_q.rd_data = q.regs.b1v1;
        b3rc_pkg::OFS_B3V1: next_q.rd_data = q.regs.b3v1;
        b3rc_pkg::OFS_B3V2: next_q.rd_data = q.regs.b3v2;
        default: next_q.rd_data = 8'h00;
      endcase
    end

    // Reference stepping shared by soft-start and slew
    if (q.state == b3rc_pkg::ST_SOFT || q.state == b3rc_pkg::ST_SLEW) begin
      if (q.step_cnt >= step_lim - 16'h0001) begin
        next_q.step_cnt = 16'h0000;
        if (q.ref_lvl < tgt) begin
          next_q.ref_lvl = q.ref_lvl + 9'h001;
        end else if (q.ref_lvl > tgt) begin
          next_q.ref_lvl = q.ref_lvl - 9'h001;
        end
      end else begin
        next_q.step_cnt = q.step_cnt + 16'h0001;
      end
    end

    // Sequencer
    unique case (q.state)
      b3rc_pkg::ST_OFF: begin
        next_q.ref_lvl = 9'h000;
        next_q.step_cnt = 16'h0000;
        if (en) begin
          next_q.state = wait_low ? b3rc_pkg::ST_WAIT : b3rc_pkg::ST_SOFT;
        end
      end
      b3rc_pkg::ST_WAIT: begin
        if (!en) begin
          next_q.state = b3rc_pkg::ST_OFF;
        end else if (VOUT_LOW) begin
          next_q.state = b3rc_pkg::ST_SOFT;
        end
      end
      b3rc_pkg::ST_SOFT: begin
        if (!en) begin
          next_q.state = b3rc_pkg::ST_OFF;
        end else if (q.ref_lvl >= tgt) begin
          next_q.ref_lvl = tgt;
          next_q.state = b3rc_pkg::ST_RUN;
        end
      end
      b3rc_pkg::ST_RUN: begin
        next_q.step_cnt = 16'h0000;
        if (!en) begin
          next_q.state = b3rc_pkg::ST_OFF;
        end else if (slew_req && q.ref_lvl != sel_tgt) begin
          next_q.state = b3rc_pkg::ST_SLEW;
        end
      end
      b3rc_pkg::ST_SLEW: begin
        if (!en) begin
          next_q.state = b3rc_pkg::ST_OFF;
        end else if (q.ref_lvl == tgt) begin
          next_q.state = b3rc_pkg::ST_RUN;
        end
      end
    endcase

    next_q.run = q.state == b3rc_pkg::ST_SOFT || q.state == b3rc_pkg::ST_RUN ||
                 q.state == b3rc_pkg::ST_SLEW;
    next_q.mode_out = (q.state == b3rc_pkg::ST_SOFT) ? b3rc_pkg::MODE_SKIP
                    : mode_fld;
    next_q.slewing = q.state == b3rc_pkg::ST_SLEW;
    next_q.power_good_output = PG_SENSE && (q.state == b3rc_pkg::ST_RUN ||
                   (q.state == b3rc_pkg::ST_SLEW && q.regs.b3v1[b3rc_pkg::PGN_BIT]));

    // Switching clock and phase
    next_q.ph_cnt = (q.ph_cnt >= per - 7'h01) ? 7'h00 : q.ph_cnt + 7'h01;
    next_q.sw_clk = q.ph_cnt < hi;
    if (pos == 7'h00 && next_q.run && q.run) begin
      next_q.cyc_start = ON_TIME_CYC >= b3rc_pkg::MIN_ON_CYC;
      next_q.cyc_skip = ON_TIME_CYC < b3rc_pkg::MIN_ON_CYC;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      q <= '0;
      q.state <= b3rc_pkg::ST_OFF;
      q.regs.mode <= b3rc_pkg::RST_MODE;
      q.regs.output_enable_control <= b3rc_pkg::RST_OUTPUT_ENABLE_CONTROL;
      q.regs.wstart <= b3rc_pkg::RST_WAIT;
      q.regs.vchg <= b3rc_pkg::RST_VCHG;
      q.regs.ramp <= b3rc_pkg::RST_RAMP;
      q.regs.b1v1 <= b3rc_pkg::RST_B1V1;
      q.regs.b3v1 <= b3rc_pkg::RST_B3V1;
      q.regs.b3v2 <= b3rc_pkg::RST_B3V2;
    end else begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign RD_DATA = q.rd_data;
  assign RD_VALID = q.rd_valid;
  assign REF_CODE = q.ref_lvl;
  assign RUN_OUT = q.run;
  assign MODE_OUT = q.mode_out;
  assign SW_CLK = q.sw_clk;
  assign CYCLE_START = q.cyc_start;
  assign CYCLE_SKIP = q.cyc_skip;
  assign POWER_GOOD = q.power_good_output;
  assign SLEWING = q.slewing;
  assign EDGE_RATE = q.regs.b1v1[b3rc_pkg::EDGE_LSB +: 2];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  chk_mode_select: assert property (q.state == b3rc_pkg::ST_RUN |=>
    MODE_OUT == $past(mode_fld)) else $error("Mode output does not follow field");

  chk_soft_skip: assert property (q.state == b3rc_pkg::ST_SOFT |=>
    MODE_OUT == b3rc_pkg::MODE_SKIP) else $error("Pulse skipping not forced in ramp");

  chk_enable_off: assert property (!q.regs.output_enable_control[b3rc_pkg::OUTPUT_ENABLE_CONTROL_BIT] |=>
    q.state == b3rc_pkg::ST_OFF ##1 !RUN_OUT) else $error("Runs with enable clear");

  chk_wait_low: assert property (q.state == b3rc_pkg::ST_WAIT && !VOUT_LOW |=>
    q.state inside {b3rc_pkg::ST_WAIT, b3rc_pkg::ST_OFF}) else $error("Left wait early");

  chk_slew_end: assert property (q.state == b3rc_pkg::ST_SLEW &&
    next_q.state == b3rc_pkg::ST_RUN |-> q.ref_lvl == tgt) else $error("Slew ended off target");

  chk_slew_start: assert property (slew_req && q.state == b3rc_pkg::ST_RUN &&
    q.ref_lvl != sel_tgt && en |=> q.state == b3rc_pkg::ST_SLEW ##1 SLEWING)
    else $error("Slew not started");

  chk_slew_rate: assert property ($past(q.state) == b3rc_pkg::ST_SLEW &&
    q.state == b3rc_pkg::ST_SLEW && $changed(q.ref_lvl) |->
    $past(q.step_cnt) == $past(step_lim) - 16'h0001) else $error("Slew step early");

  chk_power_good_output_slew: assert property (q.state == b3rc_pkg::ST_SLEW &&
    !q.regs.b3v1[b3rc_pkg::PGN_BIT] |=> !POWER_GOOD) else $error("Power-good high in slew");

  chk_period_wrap: assert property (q.ph_cnt == per - 7'h01 && $stable(half) |=>
    q.ph_cnt == 7'h00) else $error("Switching period wrong");

  chk_phase_delay: assert property (CYCLE_START |->
    $past(q.ph_cnt) == $past(dly)) else $error("Cycle start not at phase delay");

  chk_keep_alive: assert property (SHUTDOWN && q.regs.b3v2[b3rc_pkg::KEEP_BIT] &&
    q.state == b3rc_pkg::ST_RUN && q.regs.output_enable_control[b3rc_pkg::OUTPUT_ENABLE_CONTROL_BIT] && !FAULT |=>
    q.state != b3rc_pkg::ST_OFF) else $error("Kept-alive regulator shut down");

  chk_min_on: assert property (CYCLE_START |->
    $past(ON_TIME_CYC) >= b3rc_pkg::MIN_ON_CYC) else $error("On-time below minimum");

  // ---------------------------------------------------------------
  // Sequencing and switching checks
  // ---------------------------------------------------------------
  chk_off_idle: assert property (q.state == b3rc_pkg::ST_OFF |=>
    !RUN_OUT && REF_CODE == 9'h000) else $error("Output active while off");

  chk_fault_off: assert property (FAULT |=> q.state == b3rc_pkg::ST_OFF)
    else $error("Fault did not stop regulator");

  chk_quit_off: assert property (SHUTDOWN && !q.regs.b3v2[b3rc_pkg::KEEP_BIT] |=>
    q.state == b3rc_pkg::ST_OFF) else $error("Shutdown ignored");

  chk_wait_enter: assert property (q.state == b3rc_pkg::ST_OFF && en &&
    q.regs.wstart[b3rc_pkg::WAIT_BIT] == VARIANT_SWAP |=> q.state == b3rc_pkg::ST_WAIT)
    else $error("Start wait skipped");

  chk_wait_skip: assert property (q.state == b3rc_pkg::ST_OFF && en &&
    q.regs.wstart[b3rc_pkg::WAIT_BIT] != VARIANT_SWAP |=> q.state == b3rc_pkg::ST_SOFT)
    else $error("Immediate enable waited");

  chk_soft_rate: assert property ($past(q.state) == b3rc_pkg::ST_SOFT &&
    q.state == b3rc_pkg::ST_SOFT && $changed(q.ref_lvl) |->
    $past(q.step_cnt) == b3rc_pkg::SS_STEP_CYC - 16'h0001)
    else $error("Soft-start step early");

  chk_power_good_output_keep: assert property (q.state == b3rc_pkg::ST_SLEW && PG_SENSE &&
    q.regs.b3v1[b3rc_pkg::PGN_BIT] |=> POWER_GOOD) else $error("Power-good dropped in slew");

  chk_init_read: assert property ($past(RD_EN) &&
    $past(ADDR) == b3rc_pkg::OFS_VCHG |-> RD_DATA[b3rc_pkg::INIT_BIT] == $past(SLEWING))
    else $error("Initiate bit readback wrong");

  chk_run_hold: assert property (q.state == b3rc_pkg::ST_RUN && !slew_req |=>
    q.ref_lvl == $past(q.ref_lvl)) else $error("Reference moved without initiate");

  chk_clk_high: assert property (q.ph_cnt == 7'h01 |-> SW_CLK)
    else $error("Switching clock low at period start");

  chk_clk_low: assert property (q.ph_cnt == hi + 7'h01 && $stable(half) |->
    !SW_CLK) else $error("Switching clock high past duty");

  chk_skip_short: assert property (CYCLE_SKIP |->
    $past(ON_TIME_CYC) < b3rc_pkg::MIN_ON_CYC) else $error("Cycle skipped with long on-time");

  chk_start_run: assert property (CYCLE_START || CYCLE_SKIP |-> RUN_OUT)
    else $error("Switching while stopped");

  chk_edge_write: assert property ($past(WR_EN) &&
    $past(ADDR) == b3rc_pkg::OFS_B1V1 |-> EDGE_RATE == $past(WR_DATA[7:6]))
    else $error("Edge rate not taken from write");

  chk_period_count: assert property (q.ph_cnt < per - 7'h01 |=>
    q.ph_cnt == $past(q.ph_cnt) + 7'h01) else $error("Phase counter skipped");

  cov_soft_done: cover property (q.state == b3rc_pkg::ST_SOFT ##1 q.state == b3rc_pkg::ST_RUN);
  cov_slew_done: cover property (q.state == b3rc_pkg::ST_SLEW ##1 q.state == b3rc_pkg::ST_RUN);
  cov_skip: cover property (CYCLE_SKIP);
  cov_wait: cover property (q.state == b3rc_pkg::ST_WAIT ##1 q.state == b3rc_pkg::ST_SOFT);
  cov_slew_power_good_output: cover property (SLEWING && POWER_GOOD);

endmodule

`default_nettype wire

// [tb/b3rc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module b3rc_host_model (
  input wire logic clk, // System clock
  output var logic wr_en, // Write strobe
  output var logic rd_en, // Read strobe
  output var logic [7:0] addr, // Register offset
  output var logic [7:0] wr_data, // Write data
  input wire logic [7:0] rd_data, // Read data
  input wire logic rd_valid // Read data valid
);
  // ---------------------------------------------------------------
  // Idle bus, values inverted after each transfer
  // ---------------------------------------------------------------
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'hFF;
    wr_data = 8'hFF;
  end

  // ---------------------------------------------------------------
  // Transfers, entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rd_data;
    v = rd_valid;
  endtask
endmodule

`default_nettype wire

// [tb/buck3_regulator_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module buck3_regulator_control_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic vout_low = 1'b0;
  logic fault = 1'b0;
  logic shutdown = 1'b0;
  logic pg_sense = 1'b1;
  logic [7:0] on_time = 8'h14;
  logic wr_en, rd_en, rd_valid, run_out, sw_clk, cyc_start, cyc_skip, power_good, slewing;
  logic [7:0] addr, wr_data, rd_data;
  logic [8:0] ref_code;
  logic [1:0] mode_out, edge_rate;
  int bad_count = 0;
  int checks_done = 0;
  localparam logic [7:0] RST_TAB [9] = '{b3rc_pkg::RST_MODE, b3rc_pkg::RST_OUTPUT_ENABLE_CONTROL,
    b3rc_pkg::RST_WAIT, b3rc_pkg::RST_VCHG, b3rc_pkg::RST_RAMP, b3rc_pkg::RST_B1V1,
    b3rc_pkg::RST_B3V1, b3rc_pkg::RST_B3V2, 8'h00};

  always #4 clk = ~clk;

  b3rc_top i_b3rc_top (.CLK(clk), .ARST_N(arst_n), .WR_EN(wr_en), .RD_EN(rd_en),
    .ADDR(addr), .WR_DATA(wr_data), .RD_DATA(rd_data), .RD_VALID(rd_valid),
    .VOUT_LOW(vout_low), .FAULT(fault), .SHUTDOWN(shutdown), .PG_SENSE(pg_sense),
    .ON_TIME_CYC(on_time), .REF_CODE(ref_code), .RUN_OUT(run_out), .MODE_OUT(mode_out),
    .SW_CLK(sw_clk), .CYCLE_START(cyc_start), .CYCLE_SKIP(cyc_skip),
    .POWER_GOOD(power_good), .SLEWING(slewing), .EDGE_RATE(edge_rate));

  b3rc_host_model i_b3rc_host_model (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
    .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic near(input string nm, input int n, input int e, input int tol);
    check(nm, 16'(n >= e - tol && n <= e + tol), 16'h0001);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_b3rc_host_model.wr(a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_b3rc_host_model.rd(a, d, v);
    check("rd_valid", 16'(v), 16'h0001);
    check("rd_data", 16'(d), 16'(e));
  endtask

  task automatic wait_ref(input logic [8:0] e, input int lim, output int n);
    n = 0;
    while (ref_code !== e) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        bad_count++;
        $display("[FAIL] ref_wait expected %h seen %h", e, ref_code);
        final_report();
      end
    end
  endtask

  task automatic sw_meas(output int hi, output int per, output int off);
    int r[$], f[$], s[$];
    logic prev;
    repeat (120) @(posedge clk);
    prev = sw_clk;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk);
      if (sw_clk === 1'b1 && prev === 1'b0) r.push_back(i);
      if (sw_clk === 1'b0 && prev === 1'b1 && r.size() > 0) f.push_back(i);
      if (cyc_start === 1'b1 && r.size() > 0) s.push_back(i);
      prev = sw_clk;
    end
    hi = -1;
    per = -1;
    off = -1;
    if (r.size() > 1 && f.size() > 0 && s.size() > 0) begin
      hi = f[0] - r[0];
      per = r[1] - r[0];
      off = (s[0] - r[0]) % per;
    end
  endtask

  task automatic cnt(output int ns, output int nk);
    ns = 0;
    nk = 0;
    @(posedge clk);
    repeat (300) begin
      @(posedge clk);
      ns += int'(cyc_start === 1'b1);
      nk += int'(cyc_skip === 1'b1);
    end
  endtask

  // ---------------------------------------------------------------
  // Watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("[FAIL] watchdog expected end seen hang");
    final_report();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int n, st, hi, per, o0, o1, ns, nk;
    logic [8:0] tgt;
    tick(2);
    arst_n <= 1'b1;
    for (int a = 0; a < 9; a++) rd_chk(8'(a), RST_TAB[a]);
    check("edge_rate_rst", 16'(edge_rate), 16'h0000);
    wr(b3rc_pkg::OFS_B3V1, 8'h02);
    wr(b3rc_pkg::OFS_MODE, 8'h20);
    wr(b3rc_pkg::OFS_OUTPUT_ENABLE_CONTROL, 8'h04);
    tick(20);
    check("run_waiting", 16'(run_out), 16'h0000);
    vout_low <= 1'b1;
    tick(4);
    check("run_on", 16'(run_out), 16'h0001);
    check("mode_soft", 16'(mode_out), 16'h0000);
    wait_ref(9'h020, 5000, n);
    near("soft_time", n, 32 * b3rc_pkg::SS_STEP_CYC, 130);
    for (int m = 0; m < 3; m++) begin
      wr(b3rc_pkg::OFS_MODE, 8'(m << 4));
      tick(3);
      check("mode_out", 16'(mode_out), 16'(m));
    end
    check("power_good_output_run", 16'(power_good), 16'h0001);
    pg_sense <= 1'b0;
    tick(3);
    check("power_good_output_sense", 16'(power_good), 16'h0000);
    pg_sense <= 1'b1;
    wr(b3rc_pkg::OFS_B3V2, 8'h03);
    for (int r = 0; r < 4; r++) begin
      st = b3rc_pkg::SLEW_STEP_CYC[r];
      tgt = r[0] ? 9'h020 : 9'h030;
      if (r == 3) wr(b3rc_pkg::OFS_B3V1, 8'h22);
      wr(b3rc_pkg::OFS_RAMP, 8'(r << 4));
      wr(b3rc_pkg::OFS_VCHG, r[0] ? 8'h10 : 8'h30);
      tick(3);
      check("slewing", 16'(slewing), 16'h0001);
      check("power_good_output_slew", 16'(power_good), 16'(r == 3));
      wait_ref(tgt, 2000, n);
      near("slew_time", n + 3, 16 * st, st + 6);
    end
    for (int fr = 0; fr < 2; fr++) begin
      wr(b3rc_pkg::OFS_B3V2, 8'(fr << 5) | 8'h03);
      sw_meas(hi, per, o0);
      wr(b3rc_pkg::OFS_B3V2, 8'(fr << 5) | 8'h43);
      sw_meas(hi, per, o1);
      check("sw_high", 16'(hi), fr ? 16'h0037 : 16'h000B);
      check("sw_period", 16'(per), fr ? 16'h006F : 16'h0037);
      check("phase_delay", 16'((o1 - o0 + per) % per), fr ? 16'h0037 : 16'h000B);
    end
    on_time <= 8'h0B;
    cnt(ns, nk);
    check("short_starts", 16'(ns), 16'h0000);
    check("short_skips", 16'(nk > 0), 16'h0001);
    on_time <= 8'h0C;
    cnt(ns, nk);
    check("min_skips", 16'(nk), 16'h0000);
    check("min_starts", 16'(ns > 0), 16'h0001);
    wr(b3rc_pkg::OFS_B1V1, 8'hD9);
    tick(2);
    check("edge_rate", 16'(edge_rate), 16'h0003);
    shutdown <= 1'b1;
    tick(4);
    check("run_shutdown", 16'(run_out), 16'h0000);
    shutdown <= 1'b0;
    wr(b3rc_pkg::OFS_B3V2, 8'hA3);
    shutdown <= 1'b1;
    tick(4);
    check("run_keep", 16'(run_out), 16'h0001);
    shutdown <= 1'b0;
    fault <= 1'b1;
    tick(3);
    check("run_fault", 16'(run_out), 16'h0000);
    fault <= 1'b0;
    tick(4);
    check("run_restart", 16'(run_out), 16'h0001);
    check("mode_restart", 16'(mode_out), 16'h0000);
    check("ref_restart", 16'(ref_code < 9'h010), 16'h0001);
    wr(b3rc_pkg::OFS_OUTPUT_ENABLE_CONTROL, 8'h00);
    tick(3);
    check("run_off", 16'(run_out), 16'h0000);
    final_report();
  end
endmodule

`default_nettype wire
